// ### pkg/xfer_map.svh
/*
 Register offsets, field positions, reset values and command bit
 positions for the block stream transfer control.
 Assumes a 32-bit AXI4-Lite register port with byte addresses.
*/
`ifndef XFER_MAP_SVH
`define XFER_MAP_SVH

`define ADDR_SEL 8'h00
`define ADDR_CMD 8'h04
`define ADDR_BPR 8'h08
`define ADDR_STAT 8'h0C
`define ADDR_TRIG 8'h10
`define ADDR_MODE 8'h14

`define SEL_ALL 4'hF
`define CMD_BEGIN 0
`define CMD_HALT 1
`define CMD_DISCARD 2
`define CMD_SUSPEND 3
`define CMD_CONTINUE 4
`define CMD_CAP_BEGIN 5
`define CMD_CAP_DISCARD 6
`define MODE_POL_BIT 2
`define STAT_OVF_BIT 2
`define STAT_CNT_LSB 8

`define SEL_RST 4'h0
`define METH_RST 2'h0
`define POL_RST 1'h0
`define BPR_RST 32'h00000001
`define TRIG_EN_RST 5'h00

`endif

// ### pkg/xfer_pkg.sv
/*
 Types shared by the block stream transfer control.
 Assumes nothing beyond a SystemVerilog tool.
*/
`default_nettype none
package xfer_pkg;

	// Gray along stopped, streaming, paused and paused, stopping
	typedef enum logic [1:0] {
		ST_STOPPED = 2'h0,
		ST_STREAMING = 2'h1,
		ST_PAUSED = 2'h3,
		ST_STOPPING = 2'h2
	} stream_state_e;

	typedef enum logic [1:0] {
		FLOW_BASIC = 2'h0,
		FLOW_AUTO = 2'h1,
		FLOW_MANUAL = 2'h2
	} flow_method_e;

endpackage
`default_nettype wire

// ### hw/block_stream_transfer_control.sv
/*
 Block stream transfer control: per-stream block queues, per-stream
 streaming state machines, AXI4-Lite registers and one output link.
 Assumes one clock, a processing stage that never needs back-pressure,
 DEPTH a power of two and no block longer than MAX_BLK words.
*/
`timescale 1ns/100ps
`default_nettype none
`include "xfer_map.svh"

module block_stream_transfer_control
	import xfer_pkg::*;
#(
	parameter int STREAMS = 2,
	parameter int DW = 32,
	parameter int DEPTH = 64,
	parameter int MAX_BLK = 16
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [3:0] in_stream,
	input wire logic [DW-1:0] in_data,
	input wire logic in_last,
	output logic out_valid,
	input wire logic out_ready,
	output logic [DW-1:0] out_data,
	output logic out_last,
	output logic [3:0] out_stream,
	input wire logic [4:0] trig_pin
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = PW + 1;
	localparam int SW = STREAMS > 1 ? $clog2(STREAMS) : 1;
	localparam logic [CW-1:0] MAX_BLK_C = CW'(MAX_BLK);
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

	// Write and read channel holding registers
	logic aw_hold_q;
	logic w_hold_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// Settings and shared state
	logic [3:0] sel_q;
	logic [4:0] trig_en_q;
	logic [4:0] trig_s1_q;
	logic [4:0] trig_s2_q;
	logic [4:0] trig_s3_q;
	logic [4:0] trig_lvl_q;
	logic busy_q;
	logic [3:0] cur_q;
	logic [1:0] meth_q [STREAMS];
	logic pol_q [STREAMS];
	logic [31:0] bpr_q [STREAMS];
	logic [31:0] sent_q [STREAMS];
	stream_state_e st_q [STREAMS];
	stream_state_e st_d [STREAMS];
	logic [CW-1:0] cnt_q [STREAMS];
	logic [PW-1:0] wptr_q [STREAMS];
	logic [PW-1:0] rptr_q [STREAMS];
	logic [DW:0] mem [STREAMS][DEPTH];
	logic [STREAMS-1:0] in_mid_q;
	logic [STREAMS-1:0] drop_q;
	logic [STREAMS-1:0] ovf_q;
	logic [STREAMS-1:0] disc;
	logic [STREAMS-1:0] want;
	logic [STREAMS-1:0] blk_end;
	logic any_want;
	logic [3:0] pick;
	// Stream index only as wide as the stream count needs
	wire [SW-1:0] cur_i = cur_q[SW-1:0];

	// Write decode, only once address and data are both held
	wire wr_go = aw_hold_q && w_hold_q && !bvalid_q;
	wire wr_sel = wr_go && awaddr_q == `ADDR_SEL && wstrb_q[0];
	wire wr_cmd = wr_go && awaddr_q == `ADDR_CMD && wstrb_q[0];
	wire wr_bpr = wr_go && awaddr_q == `ADDR_BPR;
	wire wr_stat = wr_go && awaddr_q == `ADDR_STAT && wstrb_q[0];
	wire wr_trig = wr_go && awaddr_q == `ADDR_TRIG && wstrb_q[0];
	wire wr_mode = wr_go && awaddr_q == `ADDR_MODE && wstrb_q[0];
	wire wr_map = awaddr_q == `ADDR_SEL || awaddr_q == `ADDR_CMD
		|| awaddr_q == `ADDR_BPR || awaddr_q == `ADDR_STAT
		|| awaddr_q == `ADDR_TRIG || awaddr_q == `ADDR_MODE;
	wire [31:0] strb_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
		{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire [31:0] bpr_wval = wdata_q & strb_mask;
	wire [6:0] cmd_w = wr_cmd ? wdata_q[6:0] : 7'h00;

	// Filtered trigger edges: a rise counts once stages two and three agree
	wire [4:0] trig_pulse = trig_s2_q & trig_s3_q & ~trig_lvl_q;
	wire [4:0] ucmd = cmd_w[4:0] | (trig_pulse & trig_en_q);

	// Readback view follows the selector; all-streams shows stream 0
	wire view_ok = sel_q != `SEL_ALL && sel_q < 4'(STREAMS);
	wire [3:0] view = view_ok ? sel_q : 4'h0;
	wire [SW-1:0] view_i = view[SW-1:0];
	wire [CW-1:0] view_cnt = cnt_q[view_i];
	wire [31:0] stat_word = {16'h0000, 8'(view_cnt), 5'h00,
		ovf_q[view_i], st_q[view_i]};
	wire [31:0] mode_word = {29'h00000000, pol_q[view_i], meth_q[view_i]};
	wire rd_map = araddr == `ADDR_SEL || araddr == `ADDR_CMD
		|| araddr == `ADDR_BPR || araddr == `ADDR_STAT
		|| araddr == `ADDR_TRIG || araddr == `ADDR_MODE;
	wire [31:0] rd_mux =
		araddr == `ADDR_SEL ? {28'h0000000, sel_q} :
		araddr == `ADDR_BPR ? bpr_q[view_i] :
		araddr == `ADDR_STAT ? stat_word :
		araddr == `ADDR_TRIG ? {27'h0000000, trig_en_q} :
		araddr == `ADDR_MODE ? mode_word : 32'h00000000;

	assign awready = !aw_hold_q;
	assign wready = !w_hold_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = !rvalid_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// Address and data may arrive in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q <= 1'h0;
			w_hold_q <= 1'h0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'h0;
			bresp_q <= 2'h0;
		end
		else
		begin
			if (awvalid && !aw_hold_q)
			begin
				aw_hold_q <= 1'h1;
				awaddr_q <= awaddr;
			end
			if (wvalid && !w_hold_q)
			begin
				w_hold_q <= 1'h1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (wr_go)
			begin
				aw_hold_q <= 1'h0;
				w_hold_q <= 1'h0;
				bvalid_q <= 1'h1;
				bresp_q <= wr_map ? 2'h0 : 2'h2;
			end
			else if (bvalid_q && bready)
				bvalid_q <= 1'h0;
		end
	end

	// Reads answer one cycle after the address; unmapped gives an error
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'h0;
			rdata_q <= 32'h00000000;
			rresp_q <= 2'h0;
		end
		else if (arvalid && !rvalid_q)
		begin
			rvalid_q <= 1'h1;
			rdata_q <= rd_mux;
			rresp_q <= rd_map ? 2'h0 : 2'h2;
		end
		else if (rvalid_q && rready)
			rvalid_q <= 1'h0;
	end

	// Global settings and trigger synchroniser
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sel_q <= `SEL_RST;
			trig_en_q <= `TRIG_EN_RST;
			trig_s1_q <= 5'h00;
			trig_s2_q <= 5'h00;
			trig_s3_q <= 5'h00;
			trig_lvl_q <= 5'h00;
		end
		else
		begin
			if (wr_sel)
				sel_q <= wdata_q[3:0];
			if (wr_trig)
				trig_en_q <= wdata_q[4:0];
			trig_s1_q <= trig_pin;
			trig_s2_q <= trig_s1_q;
			trig_s3_q <= trig_s2_q;
			trig_lvl_q <= (trig_s2_q & trig_s3_q)
				| (trig_lvl_q & (trig_s2_q | trig_s3_q));
		end
	end

	// Never stall the processing stage; overload is handled by dropping
	assign in_ready = 1'h1;

	// Link output reads the head of the locked stream's queue
	wire [DW:0] head = mem[cur_i][rptr_q[cur_i]];
	wire cur_active = st_q[cur_i] == ST_STREAMING
		|| st_q[cur_i] == ST_STOPPING;
	assign out_valid = busy_q && cur_active && cnt_q[cur_i] != '0;
	assign out_data = head[DW-1:0];
	assign out_last = head[DW];
	assign out_stream = cur_q;
	wire pop_any = out_valid && out_ready;

	// Lowest streaming stream with data wins the link
	always_comb
	begin
		any_want = 1'h0;
		pick = 4'h0;
		for (int k = STREAMS - 1; k >= 0; k--)
		begin
			if (want[k])
			begin
				any_want = 1'h1;
				pick = 4'(k);
			end
		end
	end

	// Link lock is kept until a block's last word or a discard, so blocks never interleave
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			busy_q <= 1'h0;
			cur_q <= 4'h0;
		end
		else if (!busy_q)
		begin
			busy_q <= any_want;
			cur_q <= any_want ? pick : cur_q;
		end
		else if (blk_end[cur_i] || disc[cur_i])
			busy_q <= 1'h0;
	end

	genvar i;
	generate
		for (i = 0; i < STREAMS; i++)
		begin : g_stream
			wire hit = in_valid && in_stream == 4'(i);
			wire sel_hit = sel_q == `SEL_ALL || sel_q == 4'(i);
			wire [CW-1:0] free = DEPTH_C - cnt_q[i];
			wire room = free >= MAX_BLK_C;
			// A block is admitted whole or dropped whole
			wire admit = !disc[i] && (in_mid_q[i] ? !drop_q[i] : room);
			wire wr_en = hit && admit;
			wire pop = pop_any && cur_q == 4'(i);
			wire is_auto = meth_q[i] == FLOW_AUTO;
			wire is_man = meth_q[i] == FLOW_MANUAL;
			// Reserved method codes behave as basic
			wire is_basic = !is_auto && !is_man;
			wire [4:0] u = sel_hit ? ucmd : 5'h00;
			wire cap_b = sel_hit && cmd_w[`CMD_CAP_BEGIN];
			wire cap_d = sel_hit && cmd_w[`CMD_CAP_DISCARD];
			wire do_begin = is_man ? u[`CMD_BEGIN] : is_auto && cap_b;
			wire do_halt = is_man && u[`CMD_HALT];
			wire do_disc = is_man ? u[`CMD_DISCARD] : is_auto && cap_d;
			wire do_susp = !is_basic && u[`CMD_SUSPEND];
			wire do_cont = !is_basic && u[`CMD_CONTINUE];
			wire counted = is_man && pol_q[i];
			wire mid = busy_q && cur_q == 4'(i);
			wire [31:0] sent_inc = sent_q[i] + 32'h00000001;
			wire run_done = counted && blk_end[i] && sent_inc >= bpr_q[i];

			assign disc[i] = do_disc;
			assign blk_end[i] = pop && out_last;
			assign want[i] = st_q[i] == ST_STREAMING && cnt_q[i] != '0;

			// Next state: only the listed transitions, all else ignored
			always_comb
			begin
				st_d[i] = st_q[i];
				if (is_basic)
					st_d[i] = ST_STREAMING;
				else if (do_disc)
					st_d[i] = ST_STOPPED;
				else
				begin
					case (st_q[i])
						ST_STOPPED:
							if (do_begin)
								st_d[i] = ST_STREAMING;
						ST_STREAMING:
							if (run_done)
								st_d[i] = ST_STOPPED;
							else if (do_halt)
								st_d[i] = ST_STOPPING;
							else if (do_susp)
								st_d[i] = ST_PAUSED;
						ST_PAUSED:
							if (do_halt)
								st_d[i] = ST_STOPPING;
							else if (do_cont)
								st_d[i] = ST_STREAMING;
						ST_STOPPING:
							if (!mid || blk_end[i])
								st_d[i] = ST_STOPPED;
						default:
							st_d[i] = ST_STOPPED;
					endcase
				end
			end

			// Queue storage needs no reset; pointers guard it
			always_ff @(posedge aclk)
			begin
				if (wr_en)
					mem[i][wptr_q[i]] <= {in_last, in_data};
			end

			// State, queue pointers and arrival tracking
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					st_q[i] <= ST_STOPPED;
					cnt_q[i] <= '0;
					wptr_q[i] <= '0;
					rptr_q[i] <= '0;
					in_mid_q[i] <= 1'h0;
					drop_q[i] <= 1'h0;
					sent_q[i] <= 32'h00000000;
				end
				else
				begin
					st_q[i] <= st_d[i];
					if (st_d[i] == ST_STOPPED)
						sent_q[i] <= 32'h00000000;
					else if (blk_end[i])
						sent_q[i] <= sent_inc;
					if (do_disc)
					begin
						cnt_q[i] <= '0;
						wptr_q[i] <= '0;
						rptr_q[i] <= '0;
					end
					else
					begin
						cnt_q[i] <= cnt_q[i] + CW'(wr_en) - CW'(pop);
						wptr_q[i] <= wptr_q[i] + PW'(wr_en);
						rptr_q[i] <= rptr_q[i] + PW'(pop);
					end
					if (hit)
					begin
						in_mid_q[i] <= !in_last;
						drop_q[i] <= !in_last && !admit;
					end
					else if (do_disc)
						drop_q[i] <= in_mid_q[i];
				end
			end

			// Per-stream settings follow the selector, all streams at once only when it holds the all-streams code
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					meth_q[i] <= `METH_RST;
					pol_q[i] <= `POL_RST;
					bpr_q[i] <= `BPR_RST;
					ovf_q[i] <= 1'h0;
				end
				else
				begin
					if (wr_mode && sel_hit)
					begin
						meth_q[i] <= wdata_q[1:0];
						// Automatic pins the policy to continuous
						pol_q[i] <= wdata_q[1:0] == FLOW_AUTO ? 1'h0
							: wdata_q[`MODE_POL_BIT];
					end
					if (wr_bpr && sel_hit && bpr_wval != 32'h00000000)
						bpr_q[i] <= bpr_wval;
					// Set wins over a clear in the same cycle
					if (hit && !in_mid_q[i] && !disc[i] && !room)
						ovf_q[i] <= 1'h1;
					else if (wr_stat && sel_hit && wdata_q[`STAT_OVF_BIT])
						ovf_q[i] <= 1'h0;
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// ### dv/xfer_chk.sv
/*
 Port checker for the block stream transfer control.
 Assumes binding to block_stream_transfer_control, one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module xfer_chk #(
	parameter int DW = 32
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [DW-1:0] out_data,
	input wire logic out_last,
	input wire logic [3:0] out_stream
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Handshake steps on the register port and the link
	sequence wr_both;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence rd_take;
		arvalid && arready;
	endsequence
	sequence link_wait;
		out_valid && !out_ready ##1 out_valid;
	endsequence
	// Stalled words must not slip, blocks must not interleave
	chk_in_taken: assert property (in_valid |-> in_ready)
		else $error("input word refused");
	chk_word_hold: assert property (link_wait |-> $stable(out_data) && $stable(out_last))
		else $error("link word changed while stalled");
	chk_blk_whole: assert property (out_valid && out_ready && !out_last |=> $stable(out_stream))
		else $error("block interrupted by another stream");
	chk_wr_answer: assert property (wr_both |-> ##[1:2] bvalid)
		else $error("write response late");
	chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	chk_rd_answer: assert property (rd_take |=> rvalid)
		else $error("read data late");
	chk_ar_blocked: assert property (rvalid |-> !arready)
		else $error("second read taken");
	chk_reset_quiet: assert property ($rose(aresetn) |-> !out_valid && !bvalid && !rvalid)
		else $error("outputs busy after reset");
	// Each answer is given once, then withdrawn
	chk_b_once: assert property (bvalid && bready |=> !bvalid)
		else $error("write response repeated");
	chk_r_once: assert property (rvalid && rready |=> !rvalid)
		else $error("read data repeated");
endmodule
bind block_stream_transfer_control xfer_chk #(.DW(DW)) u_xfer_chk (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
	.in_valid(in_valid),
	.in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
	.out_data(out_data), .out_last(out_last), .out_stream(out_stream)
);
`default_nettype wire

// ### dv/link_host.sv
/*
 Receiving host model: takes words off the outgoing link.
 Assumes one clock; stalls by a fixed pattern, slower when asked.
*/
`timescale 1ns/100ps
`default_nettype none
module link_host (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic slow,
	output logic out_ready
);
	logic [1:0] tick_q;
	// Free-running stall phase
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tick_q <= 2'h0;
		else
			tick_q <= tick_q + 2'h1;
	end
	// Stalls in mid-block expose words that slip
	assign out_ready = slow ? (tick_q == 2'h0) : (tick_q != 2'h3);
endmodule
`default_nettype wire

// ### dv/tb.sv
/*
 Self-checking bench for the block stream transfer control.
 Assumes the link_host model and the bound port checker.
*/
`timescale 1ns/100ps
`default_nettype none
`include "xfer_map.svh"
module tb;
	logic aclk, aresetn, slow;
	logic awvalid, wvalid, bready, arvalid, rready, in_valid, in_last;
	logic awready, wready, bvalid, arready, rvalid, out_valid, out_ready, out_last;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, in_data, out_data, seed;
	logic [1:0] bresp, rresp;
	logic [3:0] in_stream, out_stream;
	logic [4:0] trig_pin;
	logic [33:0] rq[$];
	logic [36:0] dq[$];
	int fail_count, total_checks;
	int held;
	block_stream_transfer_control dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.in_valid(in_valid), .in_ready(), .in_stream(in_stream), .in_data(in_data),
		.in_last(in_last), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
		.out_last(out_last), .out_stream(out_stream), .trig_pin(trig_pin)
	);
	link_host host (.aclk(aclk), .aresetn(aresetn), .slow(slow), .out_ready(out_ready));
	// 125 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp_reg(input logic [33:0] got, input logic [33:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("FAIL %0t reg got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_word(input logic [36:0] got, input logic [36:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("FAIL %0t word got %h exp %h", $time, got, exp);
		end
	endtask
	// Watcher pairs each answer with the oldest note
	always @(posedge aclk)
	begin
		if (bvalid && bready)
			cmp_reg({bresp, 32'h0}, rq.pop_front());
		if (rvalid && rready)
			cmp_reg({rresp, rdata}, rq.pop_front());
		if (out_valid && out_ready)
			cmp_word({out_stream, out_last, out_data}, dq.pop_front());
	end
	// Address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		rq.push_back({r, 32'h0});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			if (!aw_done && awready)
			begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready)
			begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		@(posedge aclk iff bvalid);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		rq.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge aclk iff arready);
		arvalid <= 1'b0;
		@(posedge aclk iff rvalid);
		rready <= 1'b0;
	endtask
	task automatic st(input logic [31:0] e);
		rd(`ADDR_STAT, e, 2'h0);
	endtask
	task automatic cmd(input logic [31:0] d);
		wr(`ADDR_CMD, d, 2'h0);
	endtask
	// One block of random words; kept ones are expected on the link
	task automatic blk(input logic [3:0] s, input int n, input logic keep);
		for (int i = 0; i < n; i++)
		begin
			@(posedge aclk);
			seed = lfsr(seed);
			in_valid <= 1'b1;
			in_stream <= s;
			in_data <= seed;
			in_last <= (i == n - 1);
			if (keep)
				dq.push_back({s, i == n - 1, seed});
		end
		@(posedge aclk);
		in_valid <= 1'b0;
		slow <= seed[3];
	endtask
	task automatic drain;
		while (dq.size() != 0)
			@(posedge aclk);
		repeat (4) @(posedge aclk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Hang guard, far beyond the expected few hundred cycles
	initial
	begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		tally_and_finish();
	end
	// Main sequence
	initial
	begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, in_valid, in_last, slow} = 8'h00;
		{awaddr, araddr, in_stream, trig_pin} = 25'h0000000;
		{wdata, in_data} = 64'h0;
		seed = 32'h00000049;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		st(32'h1);
		rd(`ADDR_MODE, 32'h0, 2'h0);
		rd(`ADDR_BPR, 32'h1, 2'h0);
		rd(8'h20, 32'h0, 2'h2);
		wr(8'h20, 32'h0, 2'h2);
		cmd(32'h2);
		st(32'h1);
		blk(4'h0, 3, 1'b1);
		blk(4'h1, 2, 1'b1);
		drain();
		$display("basic done");
		wr(`ADDR_SEL, 32'hF, 2'h0);
		wr(`ADDR_MODE, 32'h2, 2'h0);
		wr(`ADDR_SEL, 32'h0, 2'h0);
		cmd(32'h2);
		st(32'h0);
		blk(4'h0, 4, 1'b1);
		st(32'h0400);
		cmd(32'h1);
		drain();
		cmd(32'h8);
		blk(4'h0, 2, 1'b1);
		cmd(32'h1);
		st(32'h0203);
		cmd(32'h10);
		drain();
		cmd(32'h8);
		blk(4'h0, 3, 1'b0);
		cmd(32'h4);
		st(32'h0);
		cmd(32'h1);
		blk(4'h0, 2, 1'b1);
		drain();
		// Slow host keeps a long block in flight for pause and halt
		slow <= 1'b1;
		blk(4'h0, 16, 1'b1);
		cmd(32'h8);
		held = dq.size();
		repeat (24) @(posedge aclk);
		cmp_reg(34'(dq.size()), 34'(held));
		cmd(32'h10);
		drain();
		slow <= 1'b1;
		blk(4'h0, 16, 1'b1);
		blk(4'h0, 2, 1'b0);
		cmd(32'h2);
		drain();
		st(32'h0200);
		cmd(32'h4);
		cmd(32'h1);
		$display("manual done");
		wr(`ADDR_SEL, 32'h1, 2'h0);
		cmd(32'h2);
		st(32'h0);
		wr(`ADDR_SEL, 32'hF, 2'h0);
		st(32'h1);
		cmd(32'h1);
		wr(`ADDR_SEL, 32'h1, 2'h0);
		st(32'h1);
		wr(`ADDR_SEL, 32'hF, 2'h0);
		cmd(32'h2);
		st(32'h0);
		wr(`ADDR_SEL, 32'h1, 2'h0);
		st(32'h0);
		wr(`ADDR_SEL, 32'h0, 2'h0);
		$display("selector done");
		wr(`ADDR_MODE, 32'h6, 2'h0);
		wr(`ADDR_BPR, 32'h0, 2'h0);
		rd(`ADDR_BPR, 32'h1, 2'h0);
		wr(`ADDR_BPR, 32'h2, 2'h0);
		cmd(32'h1);
		blk(4'h0, 2, 1'b1);
		blk(4'h0, 2, 1'b1);
		blk(4'h0, 2, 1'b0);
		drain();
		st(32'h0200);
		cmd(32'h4);
		repeat (5) blk(4'h0, 16, 1'b0);
		st(32'h4004);
		wr(`ADDR_STAT, 32'h4, 2'h0);
		st(32'h4000);
		cmd(32'h4);
		wr(`ADDR_MODE, 32'h3, 2'h0);
		st(32'h1);
		$display("counted run done");
		wr(`ADDR_MODE, 32'h5, 2'h0);
		rd(`ADDR_MODE, 32'h1, 2'h0);
		cmd(32'h40);
		cmd(32'h1);
		st(32'h0);
		cmd(32'h20);
		st(32'h1);
		cmd(32'h2);
		st(32'h1);
		cmd(32'h8);
		st(32'h3);
		cmd(32'h10);
		cmd(32'h40);
		st(32'h0);
		wr(`ADDR_MODE, 32'h2, 2'h0);
		wr(`ADDR_TRIG, 32'h1, 2'h0);
		trig_pin <= 5'h01;
		repeat (8) @(posedge aclk);
		st(32'h1);
		$display("automatic and trigger done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
